// file: src/i2c_cmd_defs.svh
`ifndef I2C_CMD_DEFS_SVH
`define I2C_CMD_DEFS_SVH

// fixed upper part of the 7-bit slave address, low two bits come from pins
`define ADDR_FIXED 5'h10

// command byte fields
`define CMD_PWR_BIT 7
`define CMD_ADS_BIT 6
`define CMD_FN_MSB 6
`define CMD_FN_LSB 3
`define CMD_RS_MSB 2
`define CMD_RS_LSB 0

// {analog_digital_select, function_code} encodings
`define FN_STOP 4'h0
`define FN_PLAY 4'h5
`define FN_RECORD 4'h2
`define FN_CUE 4'h7
`define FN_DREAD 4'hc
`define FN_DWRITE 4'h9
`define FN_ERASE 4'ha

// register_select encodings
`define RS_NONE 3'h0
`define RS_ADDR 3'h1
`define RS_CONFIG_REG_0 3'h2
`define RS_CONFIG_REG_1 3'h3
`define RS_CONFIG_REG_2 3'h5

// status read: block bits of the low address byte read as zero
`define BLOCK_MASK 8'he0
`define STATUS_LAST 2'h2
`define REG_RST 16'h0000

// host command port word indices and control bits
`define HREG_DATA 2'h0
`define HREG_CTRL 2'h1
`define HREG_STAT 2'h2
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_WRITE 2
`define CTRL_READ 3
`define CTRL_NACK 4

// host serial clock: quarter period, least time rounded up
`define CLK_PERIOD_NS 8
`define SCL_PERIOD_NS 2500
`define QTR_CYC ((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))

`endif

// file: src/i2c_cmd_pkg.sv
`default_nettype none
`include "i2c_cmd_defs.svh"
package i2c_cmd_pkg;

  typedef enum logic [2:0] {
    fn_stop, fn_play, fn_record, fn_cue, fn_dread, fn_dwrite, fn_erase, fn_nop
  } func_t;

  typedef enum logic [2:0] {rs_none, rs_addr, rs_config_reg_0, rs_config_reg_1, rs_config_reg_2, rs_nop} rsel_t;

  typedef enum logic [5:0] {
    st_idle = 6'h01, st_rx = 6'h02, st_ack = 6'h04, st_wait = 6'h08, st_tx = 6'h10, st_txack = 6'h20
  } dev_state_t;

  typedef enum logic [3:0] {h_idle = 4'h1, h_start = 4'h2, h_xfer = 4'h4, h_stop = 4'h8} host_state_t;

  function automatic func_t decode_func(input logic [3:0] c);
    case (c)
      `FN_STOP: return fn_stop;
      `FN_PLAY: return fn_play;
      `FN_RECORD: return fn_record;
      `FN_CUE: return fn_cue;
      `FN_DREAD: return fn_dread;
      `FN_DWRITE: return fn_dwrite;
      `FN_ERASE: return fn_erase;
      default: return fn_nop;
    endcase
  endfunction

  function automatic rsel_t decode_rsel(input logic [2:0] c);
    case (c)
      `RS_NONE: return rs_none;
      `RS_ADDR: return rs_addr;
      `RS_CONFIG_REG_0: return rs_config_reg_0;
      `RS_CONFIG_REG_1: return rs_config_reg_1;
      `RS_CONFIG_REG_2: return rs_config_reg_2;
      default: return rs_nop;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: src/i2c_link_if.sv
`default_nettype none
// open-drain two-wire link: a line is low while either party enables its driver
interface i2c_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_scl_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = ~(host_scl_oe | dev_scl_oe);
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport dev(input scl, input sda, output dev_scl_oe, output dev_sda_oe);
  modport host(input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

// file: src/i2c_cmd_device.sv
// Overview of operation
// - first byte: seven address bits plus direction
// - slave address is 10000 then two pins
// - direction sits in first byte bit zero
// - master drives data, device drives acknowledges
// - addressed with no command: send status
// - master not-acknowledge ends device data
// - digital read: command, address, then turnaround
// - array bytes flow until master stops
// - command byte follows the address byte
// - command byte fields: power, select, function, register
// - select bit joins function bits
// - seven function codes decoded as listed
// - other nine function codes do nothing
// - register select codes, three unused do nothing
// - register load goes with any function
// - two bytes load register, high first
// - status read: status, address high, address low
// - device holds clock low until ready
`default_nettype none
`include "i2c_cmd_defs.svh"
module i2c_cmd_device (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic link_clk,
  i2c_link_if.dev link,
  input wire logic address_pin_1,
  input wire logic address_pin_0,
  input wire logic [7:0] status_in,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_req,
  output logic cmd_valid,
  output i2c_cmd_pkg::func_t func_out,
  output logic [7:0] cmd_byte,
  output logic global_power_on,
  output logic analog_digital_select,
  output logic [15:0] address_reg,
  output logic [15:0] config_reg_0,
  output logic [15:0] config_reg_1,
  output logic [15:0] config_reg_2
);
  import i2c_cmd_pkg::*;

  // link domain
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [1:0] apin_m, apin_s;
  logic ce_m, ce_s, rt_m, rt_s;
  logic [7:0] stat_m, stat_s;
  dev_state_t state;
  logic [7:0] shreg, cmd_l, hi_byte, tx_byte;
  logic [3:0] bitcnt;
  logic [2:0] byte_no;
  logic [1:0] tx_idx;
  logic dir_rd, array_mode, sda_oe, scl_oe, cmd_tog, req_tog;
  logic [15:0] addr_l, config_reg_0_l, config_reg_1_l, config_reg_2_l;
  logic rise, fall, start_c, stop_c, ready;
  // user domain
  logic ct_m, ct_s, ct_d, rq_m, rq_s, rq_d;
  logic [7:0] status_q, rd_byte;
  logic rd_tog;

  assign link.dev_scl_oe = scl_oe;
  assign link.dev_sda_oe = sda_oe;

  // pins and user-domain levels enter the link domain through two flops; lines idle high
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_m, sda_m, scl_s, sda_s} <= 4'hf;
      {apin_m, apin_s, ce_m, ce_s, rt_m, rt_s} <= 8'h00;
      {stat_m, stat_s} <= 16'h0000;
    end else begin
      {scl_m, sda_m, ce_m, rt_m} <= {link.scl, link.sda, ce, rd_tog};
      {apin_m, stat_m} <= {address_pin_1, address_pin_0, status_q};
      {scl_s, sda_s, ce_s, rt_s} <= {scl_m, sda_m, ce_m, rt_m};
      {apin_s, stat_s} <= {apin_m, stat_m};
    end
  end

  // delayed copies for edge and condition detection, frozen with the block
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      {scl_d, sda_d} <= 2'h3;
    end else if (ce_s) begin
      {scl_d, sda_d} <= {scl_s, sda_s};
    end
  end

  assign rise = scl_s & ~scl_d;
  assign fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  // array data is ready once the user side has answered the last request
  assign ready = ~array_mode | (rt_s == req_tog);

  // byte to send: array data, or the three status bytes in turn
  always_comb begin
    if (array_mode) begin
      tx_byte = rd_byte;
    end else begin
      case (tx_idx)
        2'h0: tx_byte = stat_s;
        2'h1: tx_byte = addr_l[15:8];
        default: tx_byte = addr_l[7:0] & `BLOCK_MASK;
      endcase
    end
  end

  // link protocol engine
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      {shreg, cmd_l, hi_byte} <= 24'h000000;
      {bitcnt, byte_no, tx_idx} <= 9'h000;
      {dir_rd, array_mode, sda_oe, scl_oe, cmd_tog, req_tog} <= 6'h00;
      {addr_l, config_reg_0_l, config_reg_1_l, config_reg_2_l} <= {4{`REG_RST}};
    end else if (ce_s) begin
      if (start_c) begin
        // a repeated start keeps array_mode so the turnaround reads the array
        state <= st_rx;
        bitcnt <= 4'h0;
        byte_no <= 3'h0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else if (stop_c) begin
        state <= st_idle;
        array_mode <= 1'b0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else begin
        case (state)
          st_rx: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (fall && bitcnt == 4'h8) begin
              if (byte_no == 3'h0 && shreg[7:1] != {`ADDR_FIXED, apin_s}) begin
                state <= st_idle;
              end else begin
                sda_oe <= 1'b1;
                state <= st_ack;
              end
              case (byte_no)
                3'h0: dir_rd <= shreg[0];
                3'h1: begin
                  cmd_l <= shreg;
                  array_mode <= (decode_func(shreg[`CMD_FN_MSB:`CMD_FN_LSB]) == fn_dread);
                  if (decode_rsel(shreg[`CMD_RS_MSB:`CMD_RS_LSB]) inside {rs_none, rs_nop}) begin
                    cmd_tog <= ~cmd_tog;
                  end
                end
                3'h2: hi_byte <= shreg;
                3'h3: begin
                  // load goes with whatever function came along with it
                  case (decode_rsel(cmd_l[`CMD_RS_MSB:`CMD_RS_LSB]))
                    rs_addr: addr_l <= {hi_byte, shreg};
                    rs_config_reg_0: config_reg_0_l <= {hi_byte, shreg};
                    rs_config_reg_1: config_reg_1_l <= {hi_byte, shreg};
                    rs_config_reg_2: config_reg_2_l <= {hi_byte, shreg};
                    default: ;
                  endcase
                  cmd_tog <= ~cmd_tog;
                end
                default: ;
              endcase
            end
          end
          st_ack: begin
            if (fall) begin
              sda_oe <= 1'b0;
              if (dir_rd) begin
                state <= st_wait;
                scl_oe <= 1'b1;
                tx_idx <= 2'h0;
                if (array_mode) begin
                  req_tog <= ~req_tog;
                end
              end else begin
                state <= st_rx;
                bitcnt <= 4'h0;
                if (byte_no != 3'h4) begin
                  byte_no <= byte_no + 3'h1;
                end
              end
            end
          end
          st_wait: begin
            // clock held low until the byte is in hand
            if (ready) begin
              shreg <= tx_byte;
              sda_oe <= ~tx_byte[7];
              bitcnt <= 4'h1;
              scl_oe <= 1'b0;
              state <= st_tx;
            end
          end
          st_tx: begin
            if (fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= st_txack;
              end else begin
                sda_oe <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          st_txack: begin
            if (rise && sda_s) begin
              state <= st_idle;
            end else if (fall) begin
              state <= st_wait;
              scl_oe <= 1'b1;
              tx_idx <= (tx_idx == `STATUS_LAST) ? 2'h0 : tx_idx + 2'h1;
              if (array_mode) begin
                req_tog <= ~req_tog;
              end
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  // toggles from the link domain enter the user domain through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {ct_m, ct_s, rq_m, rq_s} <= 4'h0;
    end else begin
      {ct_m, rq_m} <= {cmd_tog, req_tog};
      {ct_s, rq_s} <= {ct_m, rq_m};
    end
  end

  // command hand-over: link words are stable for many link bits after a toggle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {ct_d, cmd_valid, global_power_on, analog_digital_select} <= 4'h0;
      func_out <= fn_stop;
      cmd_byte <= 8'h00;
      {address_reg, config_reg_0, config_reg_1, config_reg_2} <= {4{`REG_RST}};
    end else if (ce) begin
      ct_d <= ct_s;
      cmd_valid <= ct_s ^ ct_d;
      if (ct_s ^ ct_d) begin
        func_out <= decode_func(cmd_l[`CMD_FN_MSB:`CMD_FN_LSB]);
        cmd_byte <= cmd_l;
        global_power_on <= cmd_l[`CMD_PWR_BIT];
        analog_digital_select <= cmd_l[`CMD_ADS_BIT];
        {address_reg, config_reg_0, config_reg_1, config_reg_2} <= {addr_l, config_reg_0_l, config_reg_1_l, config_reg_2_l};
      end
    end
  end

  // array byte requests out, answers back as a toggle with held data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rq_d, rd_req, rd_tog} <= 3'h0;
      {rd_byte, status_q} <= 16'h0000;
    end else if (ce) begin
      rq_d <= rq_s;
      rd_req <= rq_s ^ rq_d;
      status_q <= status_in;
      if (rd_valid) begin
        rd_byte <= rd_data;
        rd_tog <= ~rd_tog;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/i2c_cmd_host.sv
`default_nettype none
`include "i2c_cmd_defs.svh"
module i2c_cmd_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  i2c_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  import i2c_cmd_pkg::*;

  localparam logic [6:0] QTR_LAST = 7'(`QTR_CYC - 1);

  host_state_t state;
  logic scl_m, scl_s, sda_m, sda_s;
  logic [6:0] div;
  logic [1:0] q;
  logic [3:0] bitcnt;
  logic [7:0] dreg;
  logic op_read, nack_mode, got_nack, scl_oe, sda_oe, tick, stall;

  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;
  assign tick = (div == QTR_LAST);
  // a stretched clock freezes the sequence until the line really rises
  assign stall = (q == 2'h2) & ~scl_s;

  // bus lines come from outside the clock domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  // quarter-period divider, only runs while a sequence is active
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 7'h00;
    end else if (ce) begin
      div <= (state == h_idle || tick) ? 7'h00 : div + 7'h01;
    end
  end

  // sequencer: each step of four quarters is start, bit or stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= h_idle;
      q <= 2'h0;
      bitcnt <= 4'h0;
      dreg <= 8'h00;
      op_read <= 1'b0;
      nack_mode <= 1'b0;
      got_nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      case (state)
        h_idle: begin
          q <= 2'h0;
          bitcnt <= 4'h0;
          if (wr && addr == `HREG_DATA) begin
            dreg <= wdata;
          end
          if (wr && addr == `HREG_CTRL) begin
            op_read <= wdata[`CTRL_READ];
            nack_mode <= wdata[`CTRL_NACK];
            if (wdata[`CTRL_START]) begin
              state <= h_start;
            end else if (wdata[`CTRL_WRITE] || wdata[`CTRL_READ]) begin
              state <= h_xfer;
            end else if (wdata[`CTRL_STOP]) begin
              state <= h_stop;
            end
          end
        end
        h_start, h_stop: begin
          if (tick && !stall) begin
            q <= q + 2'h1;
            case (q)
              2'h0: sda_oe <= (state == h_stop);
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= (state == h_start);
              default: begin
                scl_oe <= (state == h_start);
                state <= h_idle;
              end
            endcase
          end
        end
        h_xfer: begin
          if (tick && !stall) begin
            q <= q + 2'h1;
            case (q)
              2'h0: begin
                // master owns data bits on writes, the ack bit on reads
                if (bitcnt == 4'h8) begin
                  sda_oe <= op_read & ~nack_mode;
                end else begin
                  sda_oe <= ~op_read & ~dreg[7];
                end
              end
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (bitcnt == 4'h8) begin
                  got_nack <= sda_s;
                end else begin
                  dreg <= {dreg[6:0], sda_s};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bitcnt <= bitcnt + 4'h1;
                if (bitcnt == 4'h8) begin
                  state <= h_idle;
                end
              end
            endcase
          end
        end
        default: state <= h_idle;
      endcase
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      if (rd) begin
        case (addr)
          `HREG_DATA: rdata <= dreg;
          `HREG_STAT: rdata <= {6'h00, got_nack, state != h_idle};
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/i2c_cmd_props.sv
`default_nettype none
`include "i2c_cmd_defs.svh"
module i2c_cmd_props (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic host_scl_oe,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic address_pin_1,
  input wire logic address_pin_0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, first, rmode, wmode, foreign, done_tx;
  logic [3:0] bit_n;
  logic [7:0] shreg, stretch_n;
  // wire events, one link clock late; the bus is far slower so nothing is missed
  wire logic scl_rise = scl && !scl_q;
  wire logic start_c = scl && scl_q && sda_q && !sda;
  wire logic stop_c = scl && scl_q && !sda_q && sda;
  wire logic ack_slot = scl_rise && bit_n == 4'h8;
  wire logic match = shreg[7:1] == {`ADDR_FIXED, address_pin_1, address_pin_0};
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!nrst);
  // previous line levels
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit position in the byte; a start restarts framing
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      bit_n <= 4'h0;
      shreg <= 8'h00;
    end else if (start_c) begin
      bit_n <= 4'h0;
    end else if (scl_rise) begin
      bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
      if (bit_n != 4'h8) shreg <= {shreg[6:0], sda};
    end
  end
  // transaction mode, settled at the address acknowledge
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      first <= 1'b0;
      rmode <= 1'b0;
      wmode <= 1'b0;
      foreign <= 1'b0;
    end else if (start_c) begin
      first <= 1'b1;
      rmode <= 1'b0;
      wmode <= 1'b0;
      foreign <= 1'b0;
    end else if (ack_slot && first) begin
      first <= 1'b0;
      rmode <= match && shreg[0];
      wmode <= match && !shreg[0];
      foreign <= !match;
    end
  end
  // set once the master refused further device data
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) done_tx <= 1'b0;
    else if (start_c || stop_c) done_tx <= 1'b0;
    else if (ack_slot && rmode && sda) done_tx <= 1'b1;
  end
  // length of the running clock stretch; counted so the bound needs no long repetition
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) stretch_n <= 8'h00;
    else stretch_n <= dev_scl_oe ? stretch_n + 8'h01 : 8'h00;
  end
  a_sda_steady: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data moved with clock high");
  a_stretch_low: assert property ($rose(dev_scl_oe) |-> host_scl_oe && !scl_q)
    else $error("stretch began while clock high");
  a_stretch_bound: assert property (stretch_n < 8'd60)
    else $error("clock stretch too long");
  a_addr_match: assert property (ack_slot && first |-> sda == !match)
    else $error("address acknowledge wrong");
  a_foreign_quiet: assert property (foreign |-> !dev_sda_oe && !dev_scl_oe)
    else $error("device active after foreign address");
  a_write_acked: assert property (ack_slot && !first && wmode |-> !sda)
    else $error("written byte not acknowledged");
  a_host_bits: assert property (scl_rise && bit_n != 4'h8 && !rmode |-> !dev_sda_oe)
    else $error("device drove a master data bit");
  a_master_ack: assert property (ack_slot && rmode |-> !dev_sda_oe)
    else $error("device drove the master acknowledge");
  a_nack_release: assert property (done_tx |-> !dev_sda_oe)
    else $error("device drove data after not-acknowledge");
endmodule
`default_nettype wire

// file: testbench/i2c_command_port_tb.sv
`default_nettype none
`include "i2c_cmd_defs.svh"
module i2c_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_cmd_pkg::*;
  localparam logic [7:0] c_start = 8'h01 << `CTRL_START;
  localparam logic [7:0] c_stop = 8'h01 << `CTRL_STOP;
  localparam logic [7:0] c_write = 8'h01 << `CTRL_WRITE;
  localparam logic [7:0] c_read = 8'h01 << `CTRL_READ;
  localparam logic [7:0] c_nack = 8'h01 << `CTRL_NACK;
  localparam logic [7:0] stat_val = 8'h5a;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic address_pin_1 = 1'b0;
  logic address_pin_0 = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic rd_valid = 1'b0;
  logic rd_req, cmd_valid, global_power_on, analog_digital_select;
  func_t func_out;
  logic [7:0] cmd_byte, rdata;
  logic [15:0] address_reg, config_reg_0, config_reg_1, config_reg_2;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] exp_a = `REG_RST;
  logic [15:0] exp_0 = `REG_RST;
  logic [15:0] exp_1 = `REG_RST;
  logic [15:0] exp_2 = `REG_RST;
  // each command pairs a function code with a register select code
  logic [7:0] cmds [8] = '{8'h82, 8'hab, 8'h95, 8'hb9, 8'hcf, 8'hd6, 8'h78, 8'he1};
  int miscompares = 0;
  int num_checks = 0;
  int cmd_n = 0;
  int req_n = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  // link clock offset so its edges never meet the user clock edges
  initial begin
    #1.5;
    forever #24 link_clk = ~link_clk;
  end
  i2c_link_if link ();
  i2c_cmd_device i2c_cmd_device_inst (.clk(clk), .nrst(nrst), .ce(ce), .link_clk(link_clk), .link(link.dev),
    .address_pin_1(address_pin_1), .address_pin_0(address_pin_0), .status_in(stat_val), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_req(rd_req), .cmd_valid(cmd_valid), .func_out(func_out), .cmd_byte(cmd_byte),
    .global_power_on(global_power_on), .analog_digital_select(analog_digital_select), .address_reg(address_reg),
    .config_reg_0(config_reg_0), .config_reg_1(config_reg_1), .config_reg_2(config_reg_2));
  i2c_cmd_host i2c_cmd_host_inst (.clk(clk), .nrst(nrst), .ce(ce), .link(link.host), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  i2c_cmd_props i2c_cmd_props_inst (.link_clk(link_clk), .nrst(nrst), .host_scl_oe(link.host_scl_oe),
    .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda),
    .address_pin_1(address_pin_1), .address_pin_0(address_pin_0));
  // array byte source answering each request on the next clock, event counters, hang guard
  always @(posedge clk) begin
    rd_valid <= rd_req;
    if (rd_req === 1'b1) begin
      rd_data <= 8'h30 + 8'(req_n);
      req_n <= req_n + 1;
    end
    if (cmd_valid === 1'b1) cmd_n <= cmd_n + 1;
    cyc <= cyc + 1;
    // about 107k cycles are needed: 35 bytes and 21 conditions at 79 cycles a quarter
    if (cyc == 120000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so take them mid-cycle
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic op(input logic [7:0] ctrl, input logic [7:0] d, output logic [7:0] st);
    int n;
    reg_wr(`HREG_DATA, d);
    reg_wr(`HREG_CTRL, ctrl);
    n = 0;
    st = 8'h01;
    while (st[0] !== 1'b0 && n < 5000) begin
      reg_rd(`HREG_STAT, st);
      n++;
    end
    // a host that never goes idle is a failure, not a silent skip
    if (st[0] !== 1'b0) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, st, 8'h00);
      end_sim();
    end
  endtask
  task automatic bus(input logic [7:0] ctrl);
    logic [7:0] st;
    op(ctrl, 8'h00, st);
  endtask
  task automatic wbyte(input logic [7:0] b, input logic nack);
    logic [7:0] st;
    op(c_write, b, st);
    check(80'(st[1]), 80'(nack));
  endtask
  task automatic rbyte(input logic nack, input logic [7:0] exp);
    logic [7:0] st, d;
    op(nack ? (c_read | c_nack) : c_read, 8'h00, st);
    reg_rd(`HREG_DATA, d);
    check(80'(d), 80'(exp));
  endtask
  function automatic func_t exp_fn(input logic [3:0] c);
    case (c)
      4'h0: return fn_stop;
      4'h5: return fn_play;
      4'h2: return fn_record;
      4'h7: return fn_cue;
      4'hc: return fn_dread;
      4'h9: return fn_dwrite;
      4'ha: return fn_erase;
      default: return fn_nop;
    endcase
  endfunction
  initial begin
    logic [7:0] c, a;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (40) @(posedge clk);
    // pins are 00: an address for pins 11 must be ignored, and so must the next byte
    bus(c_start);
    wbyte({`ADDR_FIXED, 2'h3, 1'b0}, 1'b1);
    wbyte(8'h80, 1'b1);
    bus(c_stop);
    check(80'(cmd_n), 80'(0));
    $display("foreign address done");
    for (int i = 0; i < 8; i++) begin
      c = cmds[i];
      a = {`ADDR_FIXED, 2'(i), 1'b0};
      @(posedge clk);
      {address_pin_1, address_pin_0} <= 2'(i);
      repeat (40) @(posedge clk);
      bus(c_start);
      wbyte(a, 1'b0);
      wbyte(c, 1'b0);
      if (c[2:0] inside {3'h1, 3'h2, 3'h3, 3'h5}) begin
        wbyte(c, 1'b0);
        wbyte(~c, 1'b0);
      end
      case (c[2:0])
        3'h1: exp_a = {c, ~c};
        3'h2: exp_0 = {c, ~c};
        3'h3: exp_1 = {c, ~c};
        3'h5: exp_2 = {c, ~c};
        default: ;
      endcase
      if (c[6:3] == 4'hc) begin
        bus(c_start);
        wbyte(a | 8'h01, 1'b0);
        rbyte(1'b0, 8'h30);
        rbyte(1'b1, 8'h31);
      end
      bus(c_stop);
      repeat (20) @(posedge clk);
      check(80'(cmd_n), 80'(i + 1));
      check(80'({cmd_byte, func_out, global_power_on, analog_digital_select, address_reg, config_reg_0,
        config_reg_1, config_reg_2}), 80'({c, exp_fn(c[6:3]), c[7], c[6], exp_a, exp_0, exp_1, exp_2}));
      if (c == 8'hb9) begin
        bus(c_start);
        wbyte(a | 8'h01, 1'b0);
        rbyte(1'b0, stat_val);
        rbyte(1'b0, c);
        rbyte(1'b1, ~c & `BLOCK_MASK);
        bus(c_stop);
        $display("status read done");
      end
      $display("command %h done", c);
    end
    check(80'(req_n), 80'(2));
    end_sim();
  end
endmodule
`default_nettype wire
